/* battery_afe_control_config_regs.sv */
/*
  Control and configuration register bank of a multi-cell battery
  monitor front end, with sleep/wake, temperature scan and forced reset.
  Assumes a serial bus master on SCL/SDA and a wake pin, all asynchronous.
*/
// Behaviour
// - Mux field picks cell, temperature or none
// - Four read/write user flags, kept in sleep
// - Register contents survive sleep untouched
// - Force-sleep bit sleeps, regulator switched off
// - Force-sleep bit clears on wake
// - Sleeping leaves mux field unchanged
// - Auto scan 5 of 640 ms unless disabled
// - Regulator disable bit turns internal regulator off
// - Force-on bit keeps sensor supply on
// - Force-reset bit clears every register
// - Wake pin disable blocks pin wake
// - Edge select: one rising, zero falling
// - Feature writes only while gate bit set
// - Sleep clears on power-up, wake, write zero
// - External temp select holds supply, 1 ms compare
// - Serial slave, most significant bit first
`timescale 1ns/1ps
`include "afe_cfg_map.svh"

module battery_afe_control_config_regs #(
  parameter int TICK_CYCLES = `CLK_KHZ,                // Cycles per ms
  parameter int OT_CYCLES   = `CLK_KHZ * `OT_DELAY_MS  // Supply settle
) (
  input  wire logic       ref_clk,
  input  wire logic       rstn,
  input  wire logic       sclPin,
  input  wire logic       sdaIn,
  input  wire logic       wakePin,
  output logic            sdaOut,
  output logic            sdaOeN,
  output logic            regulatorEnable,
  output logic            sensorSupplyOutput,
  output logic            overTempCompareEnable,
  output logic [3:0]      analogSelect,
  output logic            analogEnable,
  output logic            sleepState
);

  logic [7:0]  muxReg, next_muxReg;       // Flags and mux select field
  logic        sleepBit, next_sleepBit;   // Force-sleep bit
  logic [7:0]  featReg, next_featReg;     // Feature configuration
  logic [7:0]  gateReg, next_gateReg;     // Write gate and flags
  logic [1:0]  wakeSync;                  // Wake pin synchroniser
  logic        wakeD;                     // Delayed synchronised wake pin
  logic [19:0] tickCnt, next_tickCnt;     // Millisecond divider
  logic        msTick, next_msTick;       // One-cycle millisecond enable
  logic [9:0]  msCnt, next_msCnt;         // Position in scan period
  logic [19:0] otCnt, next_otCnt;         // Time since supply came on
  logic        next_supply, next_compare, next_regEn, next_anaEn;
  logic        wrStrobe;
  afe_cfg_pkg::reg_write_s wrReq;
  logic [7:0]  rdAddr, rdData;

  // Address decode used by both the write and read paths
  function automatic logic hits(input logic [7:0] a, input logic [7:0] off);
    hits = (a == off);
  endfunction

  // Serial bus slave
  twowire_slave u_slave (
    .ref_clk  (ref_clk),
    .rstn     (rstn),
    .sclPin   (sclPin),
    .sdaIn    (sdaIn),
    .rdData   (rdData),
    .rdAddr   (rdAddr),
    .wrStrobe (wrStrobe),
    .wrReq    (wrReq),
    .sdaOut   (sdaOut),
    .sdaOeN   (sdaOeN)
  );

  // Read mux, reserved bits and unmapped addresses read zero
  always_comb begin
    rdData = `RST_BYTE;
    if (hits(rdAddr, `OFF_MUX))     rdData = muxReg;
    if (hits(rdAddr, `OFF_SLEEP))   rdData = {sleepBit, 7'h00};
    if (hits(rdAddr, `OFF_FEATURE)) rdData = featReg;
    if (hits(rdAddr, `OFF_GATE))    rdData = gateReg;
  end

  wire wrMux   = wrStrobe & hits(wrReq.addr, `OFF_MUX);
  wire wrSleep = wrStrobe & hits(wrReq.addr, `OFF_SLEEP);
  wire wrGate  = wrStrobe & hits(wrReq.addr, `OFF_GATE);
  wire wrFeat  = wrStrobe & hits(wrReq.addr, `OFF_FEATURE) & gateReg[`BIT_FSET_EN];
  wire porHit  = wrFeat & wrReq.data[`BIT_POR];
  wire wakeS   = wakeSync[1];
  wire wakeRise = wakeS & ~wakeD;
  wire wakeFall = ~wakeS & wakeD;
  wire wakeEdge = featReg[`BIT_WAKE_EDGE] ? wakeRise : wakeFall;
  wire wakeEvent = sleepBit & ~featReg[`BIT_WAKE_DIS] & wakeEdge;

  // Register bank next state; nothing here reacts to sleep itself
  always_comb begin
    next_muxReg   = muxReg;
    next_sleepBit = sleepBit;
    next_featReg  = featReg;
    next_gateReg  = gateReg;
    if (porHit) begin
      // Forced reset clears everything, flags included
      next_muxReg   = `RST_BYTE;
      next_sleepBit = 1'b0;
      next_featReg  = `RST_BYTE;
      next_gateReg  = `RST_BYTE;
    end else begin
      if (wrMux) next_muxReg = wrReq.data & `MASK_MUX;
      if (wrGate) next_gateReg = wrReq.data & `MASK_GATE;
      if (wrFeat) next_featReg = wrReq.data & `MASK_FEATURE;
      if (wakeEvent) next_sleepBit = 1'b0;
      if (wrSleep) next_sleepBit = wrReq.data[`BIT_SLEEP];
    end
  end

  wire [3:0] muxSel  = muxReg[3:0];
  wire       muxValid = (muxSel != `MUX_NONE) && (muxSel <= `MUX_INT_TEMP);
  wire       autoOn  = ~featReg[`BIT_AUTO_OFF] && (msCnt < 10'(`SCAN_ON_MS));

  // Timing and output next values
  always_comb begin
    next_tickCnt = tickCnt + 20'h1;
    next_msTick  = 1'b0;
    next_msCnt   = msCnt;
    if (tickCnt >= 20'(TICK_CYCLES - 1)) begin
      next_tickCnt = 20'h0;
      next_msTick  = 1'b1;
    end
    if (msTick) begin
      next_msCnt = (msCnt >= 10'(`SCAN_PERIOD_MS - 1)) ? 10'h0 : msCnt + 10'h1;
    end
    // Sensor supply: forced, external temperature selected, or auto scan
    next_supply = ~sleepBit & (featReg[`BIT_FORCE_ON]
                  | (muxSel == `MUX_EXT_TEMP)
                  | autoOn);
    next_otCnt = sensorSupplyOutput ? otCnt : 20'h0;
    if (sensorSupplyOutput && otCnt < 20'(OT_CYCLES)) next_otCnt = otCnt + 20'h1;
    next_compare = sensorSupplyOutput & (otCnt >= 20'(OT_CYCLES));
    next_regEn   = ~sleepBit & ~featReg[`BIT_REG_DIS];
    next_anaEn   = ~sleepBit & muxValid;
  end

  // All registers of the bank and its outputs
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      muxReg    <= `RST_BYTE;
      sleepBit  <= 1'b0;
      featReg   <= `RST_BYTE;
      gateReg   <= `RST_BYTE;
      wakeSync  <= 2'h0;
      wakeD     <= 1'b0;
      tickCnt   <= 20'h0;
      msTick    <= 1'b0;
      msCnt     <= 10'h0;
      otCnt     <= 20'h0;
      regulatorEnable       <= 1'b0;
      sensorSupplyOutput    <= 1'b0;
      overTempCompareEnable <= 1'b0;
      analogSelect          <= `MUX_NONE;
      analogEnable          <= 1'b0;
      sleepState            <= 1'b0;
    end else begin
      muxReg    <= next_muxReg;
      sleepBit  <= next_sleepBit;
      featReg   <= next_featReg;
      gateReg   <= next_gateReg;
      wakeSync  <= {wakeSync[0], wakePin};
      wakeD     <= wakeSync[1];
      tickCnt   <= next_tickCnt;
      msTick    <= next_msTick;
      msCnt     <= next_msCnt;
      otCnt     <= next_otCnt;
      regulatorEnable       <= next_regEn;
      sensorSupplyOutput    <= next_supply;
      overTempCompareEnable <= next_compare;
      analogSelect          <= muxValid ? muxSel : `MUX_NONE;
      analogEnable          <= next_anaEn;
      sleepState            <= next_sleepBit;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_feature_gate_closed: assert property (wrStrobe && hits(wrReq.addr, `OFF_FEATURE)
    && !gateReg[`BIT_FSET_EN] |=> $stable(featReg))
    else $error("feature register written while gated");
  a_sleep_reg_off: assert property (wrSleep && wrReq.data[`BIT_SLEEP]
    |=> sleepBit ##1 !regulatorEnable)
    else $error("sleep did not switch regulator off");
  a_wake_clears_sleep: assert property (wakeEvent && !wrSleep && !porHit
    |=> !sleepBit)
    else $error("wake did not clear sleep");
  a_sleep_keeps_mux: assert property (wrSleep && !porHit |=> $stable(muxReg[3:0]))
    else $error("sleep write changed mux field");
  a_force_supply_on: assert property (featReg[`BIT_FORCE_ON] && !sleepBit
    |=> sensorSupplyOutput)
    else $error("forced sensor supply not on");
  a_ext_temp_supply: assert property (muxSel == `MUX_EXT_TEMP && !sleepBit
    |=> sensorSupplyOutput)
    else $error("external temp select without supply");
  a_compare_after_on: assert property (!sensorSupplyOutput
    |=> !overTempCompareEnable ##1 !overTempCompareEnable)
    else $error("compare enabled too early");
  a_por_clears_all: assert property (porHit |=> muxReg == 8'h00 && featReg == 8'h00
    && gateReg == 8'h00 && !sleepBit)
    else $error("forced reset left register set");
  a_auto_scan_off: assert property (featReg[`BIT_AUTO_OFF] && !featReg[`BIT_FORCE_ON]
    && muxSel != `MUX_EXT_TEMP |=> !sensorSupplyOutput)
    else $error("supply on with scan disabled");
  a_wake_pin_blocked: assert property (sleepBit && featReg[`BIT_WAKE_DIS] && !wrSleep
    && !porHit |=> sleepBit)
    else $error("wake pin woke while disabled");
  a_wrong_edge_ignored: assert property (sleepBit && !featReg[`BIT_WAKE_DIS]
    && (featReg[`BIT_WAKE_EDGE] ? wakeFall : wakeRise) && !wrSleep && !porHit
    |=> sleepBit)
    else $error("woke on unselected edge");
  a_flags_written: assert property (wrMux && !porHit
    |=> muxReg[7:6] == $past(wrReq.data[7:6]))
    else $error("user flags not stored");

endmodule // battery_afe_control_config_regs

/* afe_cfg_map.svh */
/*
  Offsets, field positions, reset values and timing figures of the
  configuration register bank. Assumes inclusion by its bare name.
*/
`ifndef AFE_CFG_MAP_SVH
`define AFE_CFG_MAP_SVH

// Register offsets
`define OFF_MUX       8'h03
`define OFF_SLEEP     8'h04
`define OFF_FEATURE   8'h07
`define OFF_GATE      8'h08

// Writable bits per register, reserved bits held at zero
`define MASK_MUX      8'hcf
`define MASK_GATE     8'h98
`define MASK_FEATURE  8'he3

// Field positions
`define BIT_SLEEP     7
`define BIT_AUTO_OFF  7
`define BIT_REG_DIS   6
`define BIT_FORCE_ON  5
`define BIT_POR       2
`define BIT_WAKE_DIS  1
`define BIT_WAKE_EDGE 0
`define BIT_FSET_EN   7

// Reset values
`define RST_BYTE      8'h00

// Mux select codes
`define MUX_NONE      4'h0
`define MUX_EXT_TEMP  4'h8
`define MUX_INT_TEMP  4'h9

// Timing, in their own units
`define CLK_KHZ       250000
`define SCAN_PERIOD_MS 640
`define SCAN_ON_MS    5
`define OT_DELAY_MS   1

`endif

/* afe_cfg_pkg.sv */
/*
  Types shared by the serial slave and the register bank.
  Assumes the map header supplies all numeric constants.
*/
package afe_cfg_pkg;

  // Serial slave sequencing
  typedef enum logic [3:0] {
    SL_IDLE, SL_ADDR, SL_ADDR_ACK, SL_PTR, SL_PTR_ACK,
    SL_WDATA, SL_WDATA_ACK, SL_RDATA, SL_RDATA_ACK
  } slave_state_e;

  // One committed register write
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
  } reg_write_s;

endpackage

/* twowire_slave.sv */
/*
  Two-wire serial slave: address match, register pointer, data bytes,
  reads with auto-increment. Assumes SCL and SDA arrive asynchronously
  and that ref_clk is many times faster than SCL.
*/
`timescale 1ns/1ps
`include "afe_cfg_map.svh"

module twowire_slave #(
  parameter logic [6:0] DEV_ADDR = 7'h28   // Arbitrary bus address
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rstn,
  input  wire logic                    sclPin,   // Bus clock from master
  input  wire logic                    sdaIn,    // Bus data level
  input  wire logic [7:0]              rdData,   // Byte at rdAddr
  output logic      [7:0]              rdAddr,   // Register pointer
  output logic                         wrStrobe, // Committed write pulse
  output afe_cfg_pkg::reg_write_s      wrReq,    // Write address and data
  output logic                         sdaOut,   // Always low when driven
  output logic                         sdaOeN    // Low while pulling SDA
);

  logic [1:0] sclSync;               // Two-stage synchroniser for SCL
  logic [1:0] sdaSync;               // Two-stage synchroniser for SDA
  logic       sclD;                  // Delayed synchronised SCL
  logic       sdaD;                  // Delayed synchronised SDA
  afe_cfg_pkg::slave_state_e state, next_state;
  logic [3:0] bitCnt, next_bitCnt;   // Bits of the current byte
  logic [7:0] shift, next_shift;     // Byte shifter
  logic [7:0] ptr, next_ptr;         // Register pointer
  logic       drive, next_drive;     // Pull SDA low
  logic       rdMode, next_rdMode;   // Read transfer, or master ack
  logic       next_wrStrobe;
  afe_cfg_pkg::reg_write_s next_wrReq;

  wire sclS  = sclSync[1];
  wire sdaS  = sdaSync[1];
  wire rise  = sclS & ~sclD;
  wire fall  = ~sclS & sclD;
  wire start = sclS & sclD & sdaD & ~sdaS;
  wire stop  = sclS & sclD & ~sdaD & sdaS;

  // Pin synchronisers and edge history
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclSync <= 2'h3;
      sdaSync <= 2'h3;
      sclD    <= 1'b1;
      sdaD    <= 1'b1;
    end else begin
      sclSync <= {sclSync[0], sclPin};
      sdaSync <= {sdaSync[0], sdaIn};
      sclD    <= sclSync[1];
      sdaD    <= sdaSync[1];
    end
  end

  // Byte sequencing; SDA is only changed just after SCL falls
  always_comb begin
    next_state    = state;
    next_bitCnt   = bitCnt;
    next_shift    = shift;
    next_ptr      = ptr;
    next_drive    = drive;
    next_rdMode   = rdMode;
    next_wrStrobe = 1'b0;
    next_wrReq    = wrReq;
    if (stop) begin
      next_state = afe_cfg_pkg::SL_IDLE;
      next_drive = 1'b0;
    end else if (start) begin
      next_state  = afe_cfg_pkg::SL_ADDR;
      next_bitCnt = 4'h0;
      next_drive  = 1'b0;
    end else begin
      case (state)
        // Receiving a byte, most significant bit first
        afe_cfg_pkg::SL_ADDR, afe_cfg_pkg::SL_PTR, afe_cfg_pkg::SL_WDATA: begin
          if (rise) begin
            next_shift  = {shift[6:0], sdaS};
            next_bitCnt = bitCnt + 4'h1;
          end else if (fall && bitCnt == 4'h8) begin
            next_bitCnt = 4'h0;
            next_drive  = 1'b1;
            if (state == afe_cfg_pkg::SL_ADDR) begin
              // Only our own address is acknowledged
              next_rdMode = shift[0];
              next_state  = afe_cfg_pkg::SL_ADDR_ACK;
              if (shift[7:1] != DEV_ADDR) begin
                next_state = afe_cfg_pkg::SL_IDLE;
                next_drive = 1'b0;
              end
            end else if (state == afe_cfg_pkg::SL_PTR) begin
              next_ptr   = shift;
              next_state = afe_cfg_pkg::SL_PTR_ACK;
            end else begin
              next_wrReq = '{addr: ptr, data: shift};
              next_state = afe_cfg_pkg::SL_WDATA_ACK;
            end
          end
        end
        // Address acknowledged: read starts at once, write takes pointer
        afe_cfg_pkg::SL_ADDR_ACK: begin
          if (fall) begin
            if (rdMode) begin
              next_shift = rdData;
              next_ptr   = ptr + 8'h01;
              next_drive = ~rdData[7];
              next_state = afe_cfg_pkg::SL_RDATA;
            end else begin
              next_drive = 1'b0;
              next_state = afe_cfg_pkg::SL_PTR;
            end
          end
        end
        afe_cfg_pkg::SL_PTR_ACK: begin
          if (fall) begin
            next_drive = 1'b0;
            next_state = afe_cfg_pkg::SL_WDATA;
          end
        end
        // Write is committed only when the ack bit has ended
        afe_cfg_pkg::SL_WDATA_ACK: begin
          if (fall) begin
            next_wrStrobe = 1'b1;
            next_ptr      = ptr + 8'h01;
            next_drive    = 1'b0;
            next_state    = afe_cfg_pkg::SL_WDATA;
          end
        end
        // Transmitting a byte
        afe_cfg_pkg::SL_RDATA: begin
          if (rise) begin
            next_bitCnt = bitCnt + 4'h1;
          end else if (fall) begin
            if (bitCnt == 4'h8) begin
              next_bitCnt = 4'h0;
              next_drive  = 1'b0;
              next_state  = afe_cfg_pkg::SL_RDATA_ACK;
            end else begin
              next_shift = {shift[6:0], 1'b0};
              next_drive = ~shift[6];
            end
          end
        end
        // Master ack continues the read, nack ends it
        afe_cfg_pkg::SL_RDATA_ACK: begin
          if (rise) begin
            next_rdMode = ~sdaS;
          end else if (fall) begin
            if (rdMode) begin
              next_shift = rdData;
              next_ptr   = ptr + 8'h01;
              next_drive = ~rdData[7];
              next_state = afe_cfg_pkg::SL_RDATA;
            end else begin
              next_state = afe_cfg_pkg::SL_IDLE;
            end
          end
        end
        default: begin
          next_drive = 1'b0;
        end
      endcase
    end
  end

  // Slave state registers
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state    <= afe_cfg_pkg::SL_IDLE;
      bitCnt   <= 4'h0;
      shift    <= `RST_BYTE;
      ptr      <= `RST_BYTE;
      drive    <= 1'b0;
      rdMode   <= 1'b0;
      wrStrobe <= 1'b0;
      wrReq    <= '0;
      sdaOut   <= 1'b0;
      sdaOeN   <= 1'b1;
    end else begin
      state    <= next_state;
      bitCnt   <= next_bitCnt;
      shift    <= next_shift;
      ptr      <= next_ptr;
      drive    <= next_drive;
      rdMode   <= next_rdMode;
      wrStrobe <= next_wrStrobe;
      wrReq    <= next_wrReq;
      sdaOut   <= 1'b0;
      sdaOeN   <= ~next_drive;
    end
  end

  assign rdAddr = ptr;

  // Write commit only follows the end of the data ack
  a_write_after_ack: assert property (@(posedge ref_clk) disable iff (!rstn)
    wrStrobe |-> $past(state) == afe_cfg_pkg::SL_WDATA_ACK && $past(fall))
    else $error("write committed outside ack");

endmodule // twowire_slave

/* host_bus_model.sv */
/*
  Host microcontroller model: two-wire bus master doing one-register
  writes and reads. Assumes a pull-up on the data wire, ref_clk 4 ns.
*/
`timescale 1ns/1ps

module host_bus_model (
  input  wire logic ref_clk,
  input  wire logic sdaWire, // Resolved data wire level
  output logic      sclPin,  // Bus clock, driven by the host
  output logic      sdaDrv   // One releases the wire, zero pulls low
);
  localparam logic [6:0] DEV = 7'h28; // Slave address of the device

  // Bus idle at time zero
  initial begin
    sclPin = 1'b1;
    sdaDrv = 1'b1;
  end

  // Quarter of an 80 ns bus clock
  task automatic q();
    repeat (5) @(negedge ref_clk);
  endtask

  // Start or repeated start: data falls while the clock is high
  task automatic st();
    sdaDrv = 1'b1;
    q();
    sclPin = 1'b1;
    q();
    sdaDrv = 1'b0;
    q();
    sclPin = 1'b0;
    q();
  endtask

  // Stop: data rises while the clock is high
  task automatic sp();
    sdaDrv = 1'b0;
    q();
    sclPin = 1'b1;
    q();
    sdaDrv = 1'b1;
    q();
  endtask

  // One bit: data set while clock low, wire sampled mid high
  task automatic bt(input logic b, output logic s);
    sdaDrv = b;
    q();
    sclPin = 1'b1;
    q();
    s = sdaWire;
    q();
    sclPin = 1'b0;
    q();
  endtask

  // Byte most significant bit first, then the ninth bit m
  task automatic by(input logic [7:0] d, input logic m, output logic [7:0] r,
                    output logic a);
    for (int i = 7; i >= 0; i--) begin
      bt(d[i], r[i]);
    end
    bt(m, a);
  endtask

  // Register write: address, pointer, data; ok when all three acked
  task automatic wr(input logic [7:0] addr, input logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2;
    st();
    by({DEV, 1'b0}, 1'b1, r, a0);
    by(addr, 1'b1, r, a1);
    by(data, 1'b1, r, a2);
    sp();
    ok = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
  endtask

  // Register read: set pointer, repeated start, one byte, no-ack
  task automatic rd(input logic [7:0] addr, output logic [7:0] data, output logic ok);
    logic [7:0] r;
    logic       a0, a1, a2, n;
    st();
    by({DEV, 1'b0}, 1'b1, r, a0);
    by(addr, 1'b1, r, a1);
    st();
    by({DEV, 1'b1}, 1'b1, r, a2);
    by(8'hff, 1'b1, data, n);
    sp();
    ok = (a0 === 1'b0) && (a1 === 1'b0) && (a2 === 1'b0);
  endtask
endmodule // host_bus_model

/* test_battery_afe_control_config_regs.sv */
/*
  Self-checking bench of the configuration register bank over the bus.
  Assumes the host model is compiled first; short tick counts in use.
*/
`timescale 1ns/1ps
`define CHK(n, e, g) begin numChecks++; if ((g) !== (e)) begin numErrors++; \
  $display("wrong value %s expected %h seen %h", n, e, g); end end

module test_battery_afe_control_config_regs;
  logic       ref_clk, rstn, wakePin, sclPin, sdaDrv, sdaWire, sdaOut, sdaOeN;
  logic       regulatorEnable, sensorSupplyOutput, overTempCompareEnable;
  logic       analogEnable, sleepState, ok;
  logic [3:0] analogSelect;
  logic [7:0] rv;
  int         numErrors, numChecks, cnt;
  logic [7:0] offs [5] = '{8'h03, 8'h04, 8'h07, 8'h08, 8'h05}; // Mapped plus one unmapped

  // Pull-up wire: low when the device drives, else the host level
  assign sdaWire = (sdaOeN === 1'b0) ? 1'b0 : sdaDrv;

  // 250 MHz clock
  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  battery_afe_control_config_regs #(.TICK_CYCLES(20), .OT_CYCLES(10)) dut (
    .ref_clk(ref_clk), .rstn(rstn), .sclPin(sclPin), .sdaIn(sdaWire),
    .wakePin(wakePin), .sdaOut(sdaOut), .sdaOeN(sdaOeN),
    .regulatorEnable(regulatorEnable), .sensorSupplyOutput(sensorSupplyOutput),
    .overTempCompareEnable(overTempCompareEnable), .analogSelect(analogSelect),
    .analogEnable(analogEnable), .sleepState(sleepState));

  host_bus_model host (.ref_clk(ref_clk), .sdaWire(sdaWire), .sclPin(sclPin),
                       .sdaDrv(sdaDrv));

  // Counts, verdict, end of run
  task automatic endOfTest();
    $display("checks %0d errors %0d", numChecks, numErrors);
    if (numErrors == 0 && numChecks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Wait n falling edges
  task automatic w(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Write one register, acks expected
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(a, d, ok);
    `CHK("write ack", 1'b1, ok)
  endtask

  // Read one register and compare
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, rv, ok);
    `CHK("read ack", 1'b1, ok)
    `CHK("read data", e, rv)
    `CHK("sda out", 1'b0, sdaOut)
  endtask

  // Cycles of sensor supply on within one 640 ms period
  task automatic scan(output int n);
    n = 0;
    repeat (12800) begin
      @(negedge ref_clk);
      n += (sensorSupplyOutput === 1'b1);
    end
  endtask

  // Hang guard
  initial begin
    repeat (100000) @(posedge ref_clk);
    numErrors++;
    endOfTest();
  end

  // Main sequence
  initial begin
    rstn = 1'b0;
    wakePin = 1'b1;
    numErrors = 0;
    numChecks = 0;
    w(2);
    rstn = 1'b1;
    w(4);
    `CHK("sleep", 1'b0, sleepState)
    `CHK("regulator", 1'b1, regulatorEnable)
    for (int i = 0; i < 5; i++) begin
      rdc(offs[i], 8'h00);
    end
    // Gate closed, then opened; reserved bits always written zero
    wr(8'h07, 8'h80);
    rdc(8'h07, 8'h00);
    wr(8'h08, 8'h98);
    rdc(8'h08, 8'h98);
    wr(8'h07, 8'h80);
    rdc(8'h07, 8'h80);
    // Every mux code, flags set
    for (int c = 0; c < 16; c++) begin
      wr(8'h03, {4'hc, c[3:0]});
      `CHK("mux", (c <= 9) ? c[3:0] : 4'h0, analogSelect)
      `CHK("mux enable", (c >= 1 && c <= 9), analogEnable)
    end
    // External temperature keeps supply on, compare follows
    wr(8'h03, 8'hc8);
    `CHK("supply", 1'b1, sensorSupplyOutput)
    w(14);
    `CHK("compare", 1'b1, overTempCompareEnable)
    rdc(8'h03, 8'hc8);
    wr(8'h03, 8'hc0);
    `CHK("supply", 1'b0, sensorSupplyOutput)
    `CHK("compare", 1'b0, overTempCompareEnable)
    // Force-on, then scan off and on
    wr(8'h07, 8'ha0);
    `CHK("supply", 1'b1, sensorSupplyOutput)
    wr(8'h07, 8'h80);
    scan(cnt);
    `CHK("scan off", 0, cnt)
    wr(8'h07, 8'h00);
    scan(cnt);
    `CHK("scan on", 5 * 20, cnt)
    // Internal regulator disable
    wr(8'h07, 8'hc0);
    `CHK("regulator", 1'b0, regulatorEnable)
    wr(8'h07, 8'h80);
    `CHK("regulator", 1'b1, regulatorEnable)
    // Sleep keeps registers; falling edge wakes
    wr(8'h03, 8'hc3);
    wr(8'h04, 8'h80);
    `CHK("sleep", 1'b1, sleepState)
    `CHK("regulator", 1'b0, regulatorEnable)
    `CHK("mux", 4'h3, analogSelect)
    rdc(8'h03, 8'hc3);
    rdc(8'h08, 8'h98);
    wakePin = 1'b0;
    w(10);
    `CHK("sleep", 1'b0, sleepState)
    rdc(8'h04, 8'h00);
    // Rising edge selected: a fall must not wake
    wakePin = 1'b1;
    wr(8'h07, 8'h81);
    wr(8'h04, 8'h80);
    wakePin = 1'b0;
    w(10);
    `CHK("sleep", 1'b1, sleepState)
    wakePin = 1'b1;
    w(10);
    `CHK("sleep", 1'b0, sleepState)
    // Wake pin disabled; only a bus write of zero wakes
    wr(8'h07, 8'h83);
    wr(8'h04, 8'h80);
    wakePin = 1'b0;
    w(10);
    wakePin = 1'b1;
    w(10);
    `CHK("sleep", 1'b1, sleepState)
    wr(8'h04, 8'h00);
    `CHK("sleep", 1'b0, sleepState)
    // Forced reset clears all, flags too
    wr(8'h07, 8'h84);
    for (int i = 0; i < 5; i++) begin
      rdc(offs[i], 8'h00);
    end
    endOfTest();
  end
endmodule // test_battery_afe_control_config_regs
